/* rtl/pif_pkg.sv */
/*
  constants, register map and carrier types of the peripheral interrupt flag block.
  assumes a 32-bit apb master on the core clock; only byte 0 of each word is used.
*/
package pif_pkg;

  // ************************************************************
  // register map
  // ************************************************************
  localparam logic [11:0] PIF_OFS_FLAG_1 = 12'h000;
  localparam logic [11:0] PIF_OFS_FLAG_2 = 12'h004;
  localparam logic [11:0] PIF_OFS_ENABLE_1 = 12'h008;
  localparam logic [11:0] PIF_OFS_ENABLE_2 = 12'h00C;
  localparam logic [11:0] PIF_OFS_CONTROL = 12'h010;
  localparam logic [11:0] PIF_OFS_EDGE_SEL = 12'h014;
  localparam logic [11:0] PIF_OFS_LEVELS = 12'h018;

  localparam logic [7:0] PIF_RST_REG = 8'h00;
  localparam logic [7:0] PIF_MASK_FLAG_1 = 8'h3F;
  localparam logic [7:0] PIF_MASK_FLAG_2 = 8'hDF;
  localparam logic [7:0] PIF_MASK_ENABLE_1 = 8'h3F;
  localparam logic [7:0] PIF_MASK_ENABLE_2 = 8'hDF;
  localparam logic [7:0] PIF_MASK_CONTROL = 8'h03;
  localparam logic [7:0] PIF_MASK_EDGE_SEL = 8'h3F;

  // control register fields
  localparam int PIF_BIT_GLOBAL_EN = 0;
  localparam int PIF_BIT_PERIPH_EN = 1;

  // edge select fields: pairs of rise/fall per monitored level
  localparam int PIF_BIT_OUT_OV_RISE = 0;
  localparam int PIF_BIT_OUT_OV_FALL = 1;
  localparam int PIF_BIT_IN_OV_RISE = 2;
  localparam int PIF_BIT_IN_OV_FALL = 3;
  localparam int PIF_BIT_IN_UV_RISE = 4;
  localparam int PIF_BIT_IN_UV_FALL = 5;

  // flag 2 positions of the edge-sensitive flags
  localparam int PIF_F2_OUT_OV = 3;
  localparam int PIF_F2_IN_OV = 1;
  localparam int PIF_F2_IN_UV = 0;

  localparam logic [31:0] PIF_RDATA_NONE = 32'h0000_0000;

  // ************************************************************
  // carrier types
  // ************************************************************
  typedef struct packed {
    logic bus_collision;
    logic serial_port;
    logic capcmp2;
    logic capcmp1;
    logic timer_b_match;
    logic timer_a_rollover;
  } pif_ev1_s;

  typedef struct packed {
    logic desat;
    logic adc_done;
    logic overtemp;
    logic gate_drive_uv;
  } pif_ev2_s;

  typedef struct packed {
    logic out_overvolt;
    logic in_overvolt;
    logic in_undervolt;
  } pif_lvl_s;

endpackage : pif_pkg

/* rtl/pif_edge_det.sv */
/*
  edge selector for one monitored level.
  assumes the level is synchronous to clk.
*/
`timescale 1ns/1ps
module pif_edge_det
  import pif_pkg::*;
(
  // clock and reset
  input wire logic clk,
  input wire logic reset_n,
  // level and selects
  input wire logic level,
  input wire logic rise_sel,
  input wire logic fall_sel,
  // event out
  output logic edge_pulse
);
  logic level_q;
  wire rose = level & ~level_q;
  wire fell = ~level & level_q;

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      level_q <= 1'b0;
    end else begin
      level_q <= level;
    end
  end

  // both selects set catch both edges
  assign edge_pulse = (rise_sel & rose) | (fall_sel & fell);

  edge_sel_a: assert property (@(posedge clk) disable iff (!reset_n)
    (rise_sel && level && !$past(level)) |-> edge_pulse) else $error("rise edge missed");
endmodule : pif_edge_det

/* rtl/pif_flag_reg.sv */
/*
  one byte of sticky flags with software clear by writing zero.
  assumes event pulses and write strobe on clk.
*/
`timescale 1ns/1ps
module pif_flag_reg
  import pif_pkg::*;
(
  // clock and reset
  input wire logic clk,
  input wire logic reset_n,
  // events and write port
  input wire logic [7:0] event_in,
  input wire logic wr_en,
  input wire logic [7:0] wr_data,
  input wire logic [7:0] impl_mask,
  // state
  output logic [7:0] flags
);
  logic [7:0] next_flags;

  // set wins over a clear in the same cycle; writing 1 can also set a flag
  assign next_flags = ((wr_en ? wr_data : flags) | event_in) & impl_mask;

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      flags <= PIF_RST_REG;
    end else begin
      flags <= next_flags;
    end
  end

  flag_sticky_a: assert property (@(posedge clk) disable iff (!reset_n)
    ($past(flags) != 8'h00 && !$past(wr_en)) |-> ((flags & $past(flags)) == $past(flags)))
    else $error("flag lost without write");
endmodule : pif_flag_reg

/* rtl/pif_top.sv */
/*
  peripheral interrupt enable and flag registers with apb access.
  assumes event inputs are one-cycle pulses and levels synchronous to clk.
*/
`timescale 1ns/1ps
module pif_top
  import pif_pkg::*;
(
  // clock and reset
  input wire logic clk,
  input wire logic reset_n,
  // apb slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // peripheral events
  input wire pif_ev1_s ev1,
  input wire pif_ev2_s ev2,
  input wire pif_lvl_s levels,
  // core request
  output logic periph_irq
);

  // ************************************************************
  // bus decode
  // ************************************************************
  logic [7:0] periph_irq_enable_1;
  logic [7:0] periph_irq_enable_2;
  logic [7:0] control;
  logic [7:0] edge_sel;
  logic [7:0] periph_irq_flag_1;
  logic [7:0] periph_irq_flag_2;
  logic [31:0] next_prdata;

  wire access = psel & penable;
  wire wr_lane0 = access & pwrite & pstrb[0];
  wire hit_f1 = paddr == PIF_OFS_FLAG_1;
  wire hit_f2 = paddr == PIF_OFS_FLAG_2;
  wire hit_e1 = paddr == PIF_OFS_ENABLE_1;
  wire hit_e2 = paddr == PIF_OFS_ENABLE_2;
  wire hit_ct = paddr == PIF_OFS_CONTROL;
  wire hit_es = paddr == PIF_OFS_EDGE_SEL;
  wire hit_lv = paddr == PIF_OFS_LEVELS;
  wire mapped = hit_f1 | hit_f2 | hit_e1 | hit_e2 | hit_ct | hit_es | hit_lv;
  wire wr_f1 = wr_lane0 & hit_f1;
  wire wr_f2 = wr_lane0 & hit_f2;

  // zero-wait slave; unmapped addresses answer with an error
  assign pready = 1'b1;
  assign pslverr = access & ~mapped;

  // ************************************************************
  // writable registers
  // ************************************************************
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      periph_irq_enable_1 <= PIF_RST_REG;
      periph_irq_enable_2 <= PIF_RST_REG;
      control <= PIF_RST_REG;
      edge_sel <= PIF_RST_REG;
    end else begin
      if (wr_lane0 && hit_e1) begin
        periph_irq_enable_1 <= pwdata[7:0] & PIF_MASK_ENABLE_1;
      end
      if (wr_lane0 && hit_e2) begin
        periph_irq_enable_2 <= pwdata[7:0] & PIF_MASK_ENABLE_2;
      end
      if (wr_lane0 && hit_ct) begin
        control <= pwdata[7:0] & PIF_MASK_CONTROL;
      end
      if (wr_lane0 && hit_es) begin
        edge_sel <= pwdata[7:0] & PIF_MASK_EDGE_SEL;
      end
    end
  end

  // ************************************************************
  // event shaping
  // ************************************************************
  logic out_ov_edge;
  logic in_ov_edge;
  logic in_uv_edge;

  pif_edge_det u_out_ov (
    .clk(clk), .reset_n(reset_n), .level(levels.out_overvolt),
    .rise_sel(edge_sel[PIF_BIT_OUT_OV_RISE]), .fall_sel(edge_sel[PIF_BIT_OUT_OV_FALL]),
    .edge_pulse(out_ov_edge)
  );
  pif_edge_det u_in_ov (
    .clk(clk), .reset_n(reset_n), .level(levels.in_overvolt),
    .rise_sel(edge_sel[PIF_BIT_IN_OV_RISE]), .fall_sel(edge_sel[PIF_BIT_IN_OV_FALL]),
    .edge_pulse(in_ov_edge)
  );
  pif_edge_det u_in_uv (
    .clk(clk), .reset_n(reset_n), .level(levels.in_undervolt),
    .rise_sel(edge_sel[PIF_BIT_IN_UV_RISE]), .fall_sel(edge_sel[PIF_BIT_IN_UV_FALL]),
    .edge_pulse(in_uv_edge)
  );

  // bits 7-6 of flag 1 stay zero; tx/rx sources are outside this block
  wire [7:0] ev_f1 = {2'b00, ev1};
  // bit 5 of flag 2 has no source
  wire [7:0] ev_f2 = {ev2.desat, ev2.adc_done, 1'b0, ev2.overtemp,
    out_ov_edge, ev2.gate_drive_uv, in_ov_edge, in_uv_edge};

  // ************************************************************
  // flag registers
  // ************************************************************
  pif_flag_reg u_flag_1 (
    .clk(clk), .reset_n(reset_n), .event_in(ev_f1), .wr_en(wr_f1),
    .wr_data(pwdata[7:0]), .impl_mask(PIF_MASK_FLAG_1), .flags(periph_irq_flag_1)
  );
  pif_flag_reg u_flag_2 (
    .clk(clk), .reset_n(reset_n), .event_in(ev_f2), .wr_en(wr_f2),
    .wr_data(pwdata[7:0]), .impl_mask(PIF_MASK_FLAG_2), .flags(periph_irq_flag_2)
  );

  // ************************************************************
  // request to the core
  // ************************************************************
  // per-bit enable of flag 2 sources
  wire [7:0] pend_2 = periph_irq_flag_2 & periph_irq_enable_2;
  wire [7:0] pend_1 = periph_irq_flag_1 & periph_irq_enable_1;
  wire any_pend = |{pend_1, pend_2};
  // clearing a stale flag before enabling avoids an immediate request
  assign periph_irq = any_pend & control[PIF_BIT_PERIPH_EN] & control[PIF_BIT_GLOBAL_EN];

  // ************************************************************
  // read data
  // ************************************************************
  function automatic logic [31:0] pif_word(input logic [7:0] b);
    pif_word = {24'h00_0000, b};
  endfunction : pif_word

  assign next_prdata =
    hit_f1 ? pif_word(periph_irq_flag_1) :
    hit_f2 ? pif_word(periph_irq_flag_2) :
    hit_e1 ? pif_word(periph_irq_enable_1) :
    hit_e2 ? pif_word(periph_irq_enable_2) :
    hit_ct ? pif_word(control) :
    hit_es ? pif_word(edge_sel) :
    hit_lv ? pif_word({5'b0_0000, levels}) : PIF_RDATA_NONE;

  // data output from a flop, captured in the setup cycle so it is valid in access
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      prdata <= PIF_RDATA_NONE;
    end else if (psel && !penable && !pwrite) begin
      prdata <= next_prdata;
    end
  end

  // ************************************************************
  // checks
  // ************************************************************
  desat_gate_a: assert property (@(posedge clk) disable iff (!reset_n)
    (periph_irq_flag_2[7] && !periph_irq_enable_2[7] && pend_1 == 8'h00 && pend_2[6:0] == 7'h00)
    |-> !periph_irq) else $error("desat request not gated");
  adc_gate_a: assert property (@(posedge clk) disable iff (!reset_n)
    (periph_irq_flag_2[6] && periph_irq_enable_2[6] && control == PIF_MASK_CONTROL) |-> periph_irq)
    else $error("adc request missing");
  unimpl_zero_a: assert property (@(posedge clk) disable iff (!reset_n)
    !periph_irq_flag_2[5] && !periph_irq_enable_2[5] && periph_irq_flag_1[7:6] == 2'b00)
    else $error("unimplemented bit set");
  flag_set_a: assert property (@(posedge clk) disable iff (!reset_n)
    ev2.overtemp |=> periph_irq_flag_2[4]) else $error("overtemp flag not set");
  adc_set_a: assert property (@(posedge clk) disable iff (!reset_n)
    ev2.adc_done |=> periph_irq_flag_2[6]) else $error("adc flag not set");
  timer_set_a: assert property (@(posedge clk) disable iff (!reset_n)
    ev1.timer_a_rollover |=> periph_irq_flag_1[0]) else $error("rollover flag not set");
  periph_gate_a: assert property (@(posedge clk) disable iff (!reset_n)
    !control[PIF_BIT_PERIPH_EN] |-> !periph_irq) else $error("request without periph enable");
  uv_edge_a: assert property (@(posedge clk) disable iff (!reset_n)
    (edge_sel[PIF_BIT_IN_UV_FALL] && $fell(levels.in_undervolt)) |=> periph_irq_flag_2[0])
    else $error("uv fall edge not latched");
  irq_or_a: assert property (@(posedge clk) disable iff (!reset_n)
    periph_irq |-> (any_pend && control[PIF_BIT_GLOBAL_EN])) else $error("request without source");

  // per-source gating of flag 2: a lone flag requests only through its own enable
  for (genvar g = 0; g < 8; g++) begin : gen_gate_chk
    if (PIF_MASK_ENABLE_2[g]) begin : gen_impl
      bit_block_a: assert property (@(posedge clk) disable iff (!reset_n)
        (periph_irq_flag_2[g] && !periph_irq_enable_2[g] && pend_1 == 8'h00 && pend_2 == 8'h00)
        |-> !periph_irq) else $error("flag request not gated");
      bit_pass_a: assert property (@(posedge clk) disable iff (!reset_n)
        (periph_irq_flag_2[g] && periph_irq_enable_2[g] && control == PIF_MASK_CONTROL)
        |-> periph_irq) else $error("enabled flag did not request");
    end
  end

endmodule : pif_top

/* bench/pif_src_model.sv */
/*
  stand-in for the on-chip event sources that feed the flag block.
  assumes one bench thread calls its tasks; outputs change just after clk rises.
*/
`timescale 1ns/1ps
module pif_src_model
  import pif_pkg::*;
(
  // clock
  input wire logic clk,
  // event sources
  output pif_ev1_s ev1,
  output pif_ev2_s ev2,
  output pif_lvl_s levels
);
  initial begin
    ev1 = '0;
    ev2 = '0;
    levels = '0;
  end

  // one-cycle pulses: a held pulse would set a flag again after software cleared it
  task fire(input pif_ev1_s a, input pif_ev2_s b);
    @(posedge clk);
    ev1 <= a;
    ev2 <= b;
    @(posedge clk);
    ev1 <= '0;
    ev2 <= '0;
  endtask : fire

  task set_lvl(input pif_lvl_s l);
    @(posedge clk);
    levels <= l;
  endtask : set_lvl
endmodule : pif_src_model

/* bench/tb_peripheral_interrupt_flags.sv */
/*
  self-checking bench of the flag block: apb master, event source model, read-result queue.
  assumes the zero-wait apb slave and one-cycle event pulses of the design.
*/
`timescale 1ns/1ps
module tb_peripheral_interrupt_flags
  import pif_pkg::*;
();
  localparam int CEIL = 5000;
  localparam logic [11:0] UNMAPPED = 12'h01C;
  logic clk = 1'b0;
  logic reset_n = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [11:0] paddr = '0;
  logic [31:0] pwdata = '0;
  logic [3:0] pstrb = '0;
  logic [31:0] prdata;
  logic pready, pslverr, periph_irq;
  pif_ev1_s ev1;
  pif_ev2_s ev2;
  pif_lvl_s levels;
  int err_total = 0;
  int n_compared = 0;
  int cyc = 0;
  logic [33:0] exp_q[$];
  logic [31:0] seed = 32'ha0ac;
  logic [9:0] v;
  logic [7:0] m;
  logic [7:0] fb [3] = '{8'h08, 8'h02, 8'h01};

  always #2.5 clk = ~clk;

  pif_top i_pif_top (.clk(clk), .reset_n(reset_n), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .ev1(ev1), .ev2(ev2), .levels(levels), .periph_irq(periph_irq));
  pif_src_model i_pif_src_model (.clk(clk), .ev1(ev1), .ev2(ev2), .levels(levels));

  // ************************************************************
  // helpers
  // ************************************************************
  function logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction : lfsr

  function logic [7:0] f2(input pif_ev2_s e);
    return {e.desat, e.adc_done, 1'b0, e.overtemp, 1'b0, e.gate_drive_uv, 2'b00};
  endfunction : f2

  task check(input string name, input logic [31:0] seen, input logic [31:0] exp);
    n_compared++;
    if (seen !== exp) begin
      err_total++;
      $display("Error %s expected %h seen %h", name, exp, seen);
    end
  endtask : check

  task conclude();
    $display("compared %0d mismatches %0d", n_compared, err_total);
    if (err_total == 0 && n_compared > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask : conclude

  // note the expected answer, then one setup and one access phase
  task apb(input logic w, input logic [11:0] a, input logic [7:0] d, input logic s, input logic [7:0] e,
           input logic er);
    exp_q.push_back({w, er, 24'h0, e});
    @(posedge clk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= {24'h0, d};
    pstrb <= {3'b000, s};
    @(posedge clk);
    penable <= 1'b1;
    do @(posedge clk); while (pready !== 1'b1);
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  task wr(input logic [11:0] a, input logic [7:0] d);
    apb(1'b1, a, d, 1'b1, 8'h00, 1'b0);
  endtask : wr

  task rd(input logic [11:0] a, input logic [7:0] e);
    apb(1'b0, a, 8'h00, 1'b1, e, 1'b0);
  endtask : rd

  // request is combinational: look once the write edge has settled
  task irq_is(input logic e);
    #1;
    check("periph_irq", {31'h0, periph_irq}, {31'h0, e});
  endtask : irq_is

  always @(posedge clk) begin
    logic [33:0] x;
    if (psel && penable && pready) begin
      x = exp_q.pop_front();
      check("pslverr", {31'h0, pslverr}, {31'h0, x[32]});
      if (!x[33]) check("prdata", prdata, x[31:0]);
    end
  end

  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == CEIL) begin
      err_total++;
      conclude();
    end
  end

  // ************************************************************
  // tests
  // ************************************************************
  initial begin
    repeat (20) @(posedge clk);
    reset_n <= 1'b1;
    rd(PIF_OFS_FLAG_1, PIF_RST_REG);
    rd(PIF_OFS_FLAG_2, PIF_RST_REG);
    rd(PIF_OFS_ENABLE_2, PIF_RST_REG);
    rd(PIF_OFS_CONTROL, PIF_RST_REG);
    apb(1'b0, UNMAPPED, 8'h00, 1'b1, 8'h00, 1'b1);
    apb(1'b1, UNMAPPED, 8'hFF, 1'b1, 8'h00, 1'b1);
    apb(1'b1, PIF_OFS_ENABLE_2, 8'hFF, 1'b0, 8'h00, 1'b0);
    rd(PIF_OFS_ENABLE_2, 8'h00);
    wr(PIF_OFS_ENABLE_2, 8'hFF);
    rd(PIF_OFS_ENABLE_2, 8'hDF);
    wr(PIF_OFS_FLAG_1, 8'hFF);
    rd(PIF_OFS_FLAG_1, 8'h3F);
    wr(PIF_OFS_FLAG_2, 8'hFF);
    rd(PIF_OFS_FLAG_2, 8'hDF);
    irq_is(1'b0);
    wr(PIF_OFS_FLAG_1, 8'h00);
    wr(PIF_OFS_FLAG_2, 8'h00);
    wr(PIF_OFS_ENABLE_2, 8'h00);
    $display("test registers done");
    for (int i = 0; i < 10; i++) begin
      v = 10'h001 << i;
      i_pif_src_model.fire(v[9:4], v[3:0]);
      rd(PIF_OFS_FLAG_1, {2'b00, v[9:4]});
      rd(PIF_OFS_FLAG_2, f2(v[3:0]));
      rd(PIF_OFS_FLAG_1, {2'b00, v[9:4]});
      wr(PIF_OFS_FLAG_1, 8'h00);
      wr(PIF_OFS_FLAG_2, 8'h00);
    end
    wr(PIF_OFS_FLAG_1, 8'h3F);
    fork
      wr(PIF_OFS_FLAG_1, 8'h00);
      begin
        @(posedge clk);
        i_pif_src_model.fire(6'h01, 4'h0);
      end
    join
    rd(PIF_OFS_FLAG_1, 8'h01);
    wr(PIF_OFS_FLAG_1, 8'h00);
    $display("test events done");
    for (int b = 0; b < 8; b++) begin
      if (b == 5) continue;
      m = 8'h01 << b;
      wr(PIF_OFS_FLAG_2, 8'h00);
      wr(PIF_OFS_ENABLE_2, m);
      wr(PIF_OFS_CONTROL, 8'h03);
      irq_is(1'b0);
      wr(PIF_OFS_FLAG_2, m);
      irq_is(1'b1);
      wr(PIF_OFS_ENABLE_2, ~m & PIF_MASK_ENABLE_2);
      irq_is(1'b0);
      wr(PIF_OFS_ENABLE_2, m);
      wr(PIF_OFS_CONTROL, 8'h01);
      irq_is(1'b0);
      wr(PIF_OFS_CONTROL, 8'h02);
      irq_is(1'b0);
      wr(PIF_OFS_CONTROL, 8'h00);
      wr(PIF_OFS_FLAG_2, 8'h00);
    end
    wr(PIF_OFS_ENABLE_1, 8'h3F);
    wr(PIF_OFS_CONTROL, 8'h03);
    i_pif_src_model.fire(6'h20, 4'h0);
    irq_is(1'b1);
    wr(PIF_OFS_FLAG_1, 8'h00);
    irq_is(1'b0);
    wr(PIF_OFS_CONTROL, 8'h00);
    wr(PIF_OFS_ENABLE_2, 8'h00);
    $display("test request done");
    for (int k = 0; k < 3; k++) begin
      for (int md = 0; md < 3; md++) begin
        wr(PIF_OFS_EDGE_SEL, 8'(md + 1) << (2 * k));
        i_pif_src_model.set_lvl(3'b100 >> k);
        repeat (2) @(posedge clk);
        rd(PIF_OFS_FLAG_2, (md != 1) ? fb[k] : 8'h00);
        rd(PIF_OFS_LEVELS, 8'h04 >> k);
        wr(PIF_OFS_FLAG_2, 8'h00);
        i_pif_src_model.set_lvl(3'b000);
        repeat (2) @(posedge clk);
        rd(PIF_OFS_FLAG_2, (md != 0) ? fb[k] : 8'h00);
        wr(PIF_OFS_FLAG_2, 8'h00);
      end
    end
    $display("test edges done");
    repeat (8) begin
      seed = lfsr(seed);
      wr(PIF_OFS_ENABLE_2, seed[7:0]);
      rd(PIF_OFS_ENABLE_2, seed[7:0] & PIF_MASK_ENABLE_2);
      i_pif_src_model.fire(seed[13:8], seed[17:14]);
      rd(PIF_OFS_FLAG_1, {2'b00, seed[13:8]});
      rd(PIF_OFS_FLAG_2, f2(seed[17:14]));
      wr(PIF_OFS_FLAG_1, 8'h00);
      wr(PIF_OFS_FLAG_2, 8'h00);
    end
    $display("test random done");
    conclude();
  end
endmodule : tb_peripheral_interrupt_flags
